// ==== verilog/pin_state_pkg.sv ====
// Package: operating modes, pin control carrier and reset values for the pin-state block
package pin_state_pkg;

	// Operating mode indication from the mode controller
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'h0,
		MODE_SLEEP = 3'h1,
		MODE_STANDBY = 3'h2,
		MODE_WATCH = 3'h3,
		MODE_SUBACTIVE = 3'h4
	} op_mode_t;

	localparam int STD_PINS = 13;
	localparam int HV_PINS = 32;

	// Per-pin pad controls
	typedef struct packed {
		logic out_en;
		logic out_val;
		logic pull_en;
		logic in_en;
	} pad_ctl_t;

	localparam logic [STD_PINS-1:0] STD_ZERO = 13'h0000;
	localparam logic [HV_PINS-1:0] HV_ZERO = 32'h0000_0000;

endpackage : pin_state_pkg

// ==== verilog/pad_state_sel.sv ====
// Combinational per-pin pad state selection for one pin
`timescale 1ns/1ns
`default_nettype none

module pad_state_sel (
	// Mode
	input wire pin_state_pkg::op_mode_t i_mode,
	input wire logic i_reset,
	// Pin configuration
	input wire logic i_high_voltage,
	input wire logic i_pull_option,
	input wire logic i_periph_input,
	input wire logic i_direction,
	input wire logic i_data,
	input wire logic i_held_data,
	// Result
	output var pin_state_pkg::pad_ctl_t o_ctl
);
	import pin_state_pkg::*;

	always_comb begin
		o_ctl = '0;
		if (i_reset) begin
			o_ctl.pull_en = i_pull_option;
		end else begin
			unique case (i_mode)
				MODE_ACTIVE: begin
					o_ctl.out_en = i_direction;
					o_ctl.out_val = i_data;
					o_ctl.in_en = 1'b1;
					// Standard pull-up stays on whatever direction and data say
					o_ctl.pull_en = i_pull_option && !i_high_voltage;
				end
				MODE_SLEEP: begin
					// Outputs keep the level captured on entry, inputs float unless a standard pull-up is optioned
					o_ctl.out_en = i_direction;
					o_ctl.out_val = i_held_data;
					o_ctl.pull_en = i_pull_option && !i_high_voltage;
				end
				MODE_STANDBY, MODE_WATCH, MODE_SUBACTIVE: begin
					// Standard pull-ups off; optioned high-voltage pull-downs turn on
					o_ctl.pull_en = i_pull_option && i_high_voltage;
				end
				default: o_ctl = '0;
			endcase
		end
		// Peripheral inputs are never gated; board must hold them steady
		if (i_periph_input) begin
			o_ctl.in_en = 1'b1;
		end
	end

endmodule : pad_state_sel

`default_nettype wire

// ==== verilog/port_low_power_pin_states.sv ====
// Top: pad state control for standard and high-voltage ports across reset and power modes
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - In sleep, output pins hold their entry value; input pins float unless a standard pull-up is optioned.
// - Standard pull-up option is on in active and sleep regardless of registers.
// - Standby, watch, subactive turn standard pull-ups off; those pins float.
// - In reset, standard pins pull up if optioned, else float.
// - High-voltage pins pull down in reset and deep modes if optioned, else float.
// - Peripheral input buffers stay enabled in every power-down mode.
// - Dedicated high-voltage input pin is high impedance except in active mode.
module port_low_power_pin_states (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RESET,
	// Mode controller
	input wire pin_state_pkg::op_mode_t I_MODE,
	// Mask options
	input wire logic [pin_state_pkg::STD_PINS-1:0] I_STD_PULLUP_OPT,
	input wire logic [pin_state_pkg::HV_PINS-1:0] I_HV_PULLDOWN_OPT,
	input wire logic I_HV_INPUT_OPT,
	// Port registers and function select
	input wire logic [pin_state_pkg::STD_PINS-1:0] I_STD_PORT_DIRECTION_REGISTER,
	input wire logic [pin_state_pkg::STD_PINS-1:0] I_STD_PORT_OUTPUT_REGISTER,
	input wire logic [pin_state_pkg::STD_PINS-1:0] I_STD_PERIPH_IN,
	input wire logic [pin_state_pkg::HV_PINS-1:0] I_HV_PORT_DIRECTION_REGISTER,
	input wire logic [pin_state_pkg::HV_PINS-1:0] I_HV_PORT_OUTPUT_REGISTER,
	input wire logic [pin_state_pkg::HV_PINS-1:0] I_HV_PERIPH_IN,
	// Standard pads
	output logic [pin_state_pkg::STD_PINS-1:0] O_STD_OE,
	output logic [pin_state_pkg::STD_PINS-1:0] O_STD_OUT,
	output logic [pin_state_pkg::STD_PINS-1:0] O_STD_PULLUP_EN,
	output logic [pin_state_pkg::STD_PINS-1:0] O_STD_IN_EN,
	// High-voltage pads
	output logic [pin_state_pkg::HV_PINS-1:0] O_HV_OE,
	output logic [pin_state_pkg::HV_PINS-1:0] O_HV_OUT,
	output logic [pin_state_pkg::HV_PINS-1:0] O_HV_PULLDOWN_EN,
	output logic [pin_state_pkg::HV_PINS-1:0] O_HV_IN_EN,
	// Dedicated high-voltage input pin
	output logic O_HVIN_IN_EN,
	output logic O_HVIN_PULLDOWN_EN
);
	import pin_state_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Sleep freezes the output data; every other mode keeps tracking it
	function automatic logic tracks_data(input op_mode_t mode);
		return mode != MODE_SLEEP;
	endfunction : tracks_data

	// Dedicated input gate: only with the input option, out of reset, in active mode
	function automatic logic hvin_gate(input logic opt, input logic rst, input op_mode_t mode);
		return opt && !rst && (mode == MODE_ACTIVE);
	endfunction : hvin_gate

	////////////////////////////////////////////////////////////////////////////////
	// Sleep entry capture
	// The value in force at the last edge before sleep is frozen, so a write
	// landing on the entry edge itself cannot leak onto the pins.

	logic [STD_PINS-1:0] std_held_ff;
	logic [HV_PINS-1:0] hv_held_ff;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			std_held_ff <= STD_ZERO;
		end else if (tracks_data(I_MODE)) begin
			std_held_ff <= I_STD_PORT_OUTPUT_REGISTER;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			hv_held_ff <= HV_ZERO;
		end else if (tracks_data(I_MODE)) begin
			hv_held_ff <= I_HV_PORT_OUTPUT_REGISTER;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin selection

	pad_ctl_t std_ctl [STD_PINS];
	pad_ctl_t hv_ctl [HV_PINS];
	logic [STD_PINS-1:0] nxt_std_oe, nxt_std_out, nxt_std_pu, nxt_std_in;
	logic [HV_PINS-1:0] nxt_hv_oe, nxt_hv_out, nxt_hv_pd, nxt_hv_in;

	for (genvar i = 0; i < STD_PINS; i++) begin : g_std
		pad_state_sel u_sel (
			.i_mode(I_MODE),
			.i_reset(I_RESET),
			.i_high_voltage(1'b0),
			.i_pull_option(I_STD_PULLUP_OPT[i]),
			.i_periph_input(I_STD_PERIPH_IN[i]),
			.i_direction(I_STD_PORT_DIRECTION_REGISTER[i]),
			.i_data(I_STD_PORT_OUTPUT_REGISTER[i]),
			.i_held_data(std_held_ff[i]),
			.o_ctl(std_ctl[i])
		);
		assign nxt_std_oe[i] = std_ctl[i].out_en;
		assign nxt_std_out[i] = std_ctl[i].out_val;
		assign nxt_std_pu[i] = std_ctl[i].pull_en;
		assign nxt_std_in[i] = std_ctl[i].in_en;
	end

	for (genvar j = 0; j < HV_PINS; j++) begin : g_hv
		pad_state_sel u_sel (
			.i_mode(I_MODE),
			.i_reset(I_RESET),
			.i_high_voltage(1'b1),
			.i_pull_option(I_HV_PULLDOWN_OPT[j]),
			.i_periph_input(I_HV_PERIPH_IN[j]),
			.i_direction(I_HV_PORT_DIRECTION_REGISTER[j]),
			.i_data(I_HV_PORT_OUTPUT_REGISTER[j]),
			.i_held_data(hv_held_ff[j]),
			.o_ctl(hv_ctl[j])
		);
		assign nxt_hv_oe[j] = hv_ctl[j].out_en;
		assign nxt_hv_out[j] = hv_ctl[j].out_val;
		assign nxt_hv_pd[j] = hv_ctl[j].pull_en;
		assign nxt_hv_in[j] = hv_ctl[j].in_en;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered pad outputs
	// One cycle of latency is accepted so every pad control is glitch free.

	// Standard output enables
	always_ff @(posedge I_CLK) begin
		O_STD_OE <= nxt_std_oe;
	end

	// Standard output data
	always_ff @(posedge I_CLK) begin
		O_STD_OUT <= nxt_std_out;
	end

	// Standard pull-ups
	always_ff @(posedge I_CLK) begin
		O_STD_PULLUP_EN <= nxt_std_pu;
	end

	// Standard input gates
	always_ff @(posedge I_CLK) begin
		O_STD_IN_EN <= nxt_std_in;
	end

	// High-voltage output enables
	always_ff @(posedge I_CLK) begin
		O_HV_OE <= nxt_hv_oe;
	end

	// High-voltage output data
	always_ff @(posedge I_CLK) begin
		O_HV_OUT <= nxt_hv_out;
	end

	// High-voltage pull-downs
	always_ff @(posedge I_CLK) begin
		O_HV_PULLDOWN_EN <= nxt_hv_pd;
	end

	// High-voltage input gates
	always_ff @(posedge I_CLK) begin
		O_HV_IN_EN <= nxt_hv_in;
	end

	// Without the input option the dedicated pin is not ours to control
	always_ff @(posedge I_CLK) begin
		O_HVIN_IN_EN <= hvin_gate(I_HV_INPUT_OPT, I_RESET, I_MODE);
	end

	// The dedicated input never carries a pull-down, so it floats off active mode
	always_ff @(posedge I_CLK) begin
		O_HVIN_PULLDOWN_EN <= 1'b0;
	end

endmodule : port_low_power_pin_states

`default_nettype wire

// ==== dv/pin_state_props.sv ====
// Checker: pad state assertions for the pin-state block
`timescale 1ns/1ns
`default_nettype none
module pin_state_props import pin_state_pkg::*; (
	input wire logic I_CLK, I_RESET,
	input wire op_mode_t I_MODE,
	input wire logic [STD_PINS-1:0] I_STD_PULLUP_OPT, I_STD_PORT_DIRECTION_REGISTER, I_STD_PERIPH_IN,
	input wire logic [HV_PINS-1:0] I_HV_PULLDOWN_OPT, I_HV_PORT_DIRECTION_REGISTER, I_HV_PORT_OUTPUT_REGISTER,
	input wire logic [STD_PINS-1:0] O_STD_OE, O_STD_PULLUP_EN, O_STD_IN_EN,
	input wire logic [HV_PINS-1:0] O_HV_OE, O_HV_OUT, O_HV_PULLDOWN_EN,
	input wire logic O_HVIN_IN_EN, O_HVIN_PULLDOWN_EN
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	logic deep;
	assign deep = I_MODE inside {MODE_STANDBY, MODE_WATCH, MODE_SUBACTIVE};
	sequence s_sleep2; I_MODE == MODE_SLEEP ##1 I_MODE == MODE_SLEEP; endsequence
	property p_hold; s_sleep2 |=> $stable(O_HV_OUT & O_HV_OE); endproperty
	a_hold: assert property (p_hold) else $error("held output moved in sleep");
	property p_sleep_oe; I_MODE == MODE_SLEEP |=> O_STD_OE == $past(I_STD_PORT_DIRECTION_REGISTER); endproperty
	a_sleep_oe: assert property (p_sleep_oe) else $error("sleep output enable wrong");
	property p_pullup; I_MODE == MODE_ACTIVE || I_MODE == MODE_SLEEP |=> O_STD_PULLUP_EN == $past(I_STD_PULLUP_OPT);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not on");
	property p_deep_std; deep |=> O_STD_PULLUP_EN == '0 && O_STD_OE == '0; endproperty
	a_deep_std: assert property (p_deep_std) else $error("standard pin not floating");
	property p_rst; $fell(I_RESET) |-> O_STD_OE == '0 && O_STD_PULLUP_EN == $past(I_STD_PULLUP_OPT); endproperty
	a_rst: assert property (p_rst) else $error("reset pad state wrong");
	property p_hv_deep; deep |=> O_HV_PULLDOWN_EN == $past(I_HV_PULLDOWN_OPT) && O_HV_OE == '0; endproperty
	a_hv_deep: assert property (p_hv_deep) else $error("pull-down wrong");
	property p_periph; I_MODE != MODE_ACTIVE |=> (O_STD_IN_EN & $past(I_STD_PERIPH_IN)) == $past(I_STD_PERIPH_IN);
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral input gated");
	property p_hvin; I_MODE != MODE_ACTIVE |=> !O_HVIN_IN_EN && !O_HVIN_PULLDOWN_EN; endproperty
	a_hvin: assert property (p_hvin) else $error("dedicated input not floating");
	property p_active; I_MODE == MODE_ACTIVE |=> O_HV_OE == $past(I_HV_PORT_DIRECTION_REGISTER) &&
		O_HV_OUT == $past(I_HV_PORT_OUTPUT_REGISTER); endproperty
	a_active: assert property (p_active) else $error("active drive wrong");
endmodule : pin_state_props
bind port_low_power_pin_states pin_state_props i_pin_state_props (.*);
`default_nettype wire

// ==== dv/board_pins.sv ====
// Partner: board circuitry resolving standard pin levels
`timescale 1ns/1ns
`default_nettype none
module board_pins import pin_state_pkg::*; (
	input wire logic i_clk,
	input wire logic [STD_PINS-1:0] i_oe, i_out, i_pull, i_periph,
	output logic [STD_PINS-1:0] o_level
);
	logic float_ff = 1'b0;
	// Floating pins wander so a missing drive never reads as a clean level
	always @(posedge i_clk) float_ff <= ~float_ff;
	always_comb for (int i = 0; i < STD_PINS; i++) o_level[i] = i_oe[i] ? i_out[i] : (i_pull[i] | i_periph[i]) ? 1'b1 : float_ff;
endmodule : board_pins
`default_nettype wire

// ==== dv/port_low_power_pin_states_test.sv ====
// Testbench: pad states through reset and each power mode
`timescale 1ns/1ns
`default_nettype none
module port_low_power_pin_states_test;
	import pin_state_pkg::*;
	logic I_CLK = 0, I_RESET = 1, I_HV_INPUT_OPT = 1, O_HVIN_IN_EN, O_HVIN_PULLDOWN_EN;
	op_mode_t I_MODE = MODE_ACTIVE;
	logic [STD_PINS-1:0] I_STD_PULLUP_OPT = 13'h0a5a, I_STD_PORT_DIRECTION_REGISTER = 13'h1f0f, I_STD_PERIPH_IN = 13'h0101;
	logic [STD_PINS-1:0] I_STD_PORT_OUTPUT_REGISTER = 13'h0ff3, O_STD_OE, O_STD_OUT, O_STD_PULLUP_EN, O_STD_IN_EN, lvl, old;
	logic [HV_PINS-1:0] I_HV_PULLDOWN_OPT = 32'h1234_5678, I_HV_PORT_DIRECTION_REGISTER = 32'hffff_0000;
	logic [HV_PINS-1:0] I_HV_PORT_OUTPUT_REGISTER = 32'h5a5a_a5a5, I_HV_PERIPH_IN = 32'h0000_00f0;
	logic [HV_PINS-1:0] O_HV_OE, O_HV_OUT, O_HV_PULLDOWN_EN, O_HV_IN_EN, old_hv;
	int errors = 0, n_checks = 0;
	port_low_power_pin_states i_port_low_power_pin_states (.*);
	board_pins i_board_pins (.i_clk(I_CLK), .i_oe(O_STD_OE), .i_out(O_STD_OUT), .i_pull(O_STD_PULLUP_EN),
		.i_periph(I_STD_PERIPH_IN), .o_level(lvl));
	initial forever #50 I_CLK = ~I_CLK;
	task step; @(posedge I_CLK); #10; endtask : step
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task end_of_test;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task t_reset;
		I_RESET = 1;
		repeat (12) step();
		chk("std oe", 0, 32'(O_STD_OE));
		chk("std pull", 32'(I_STD_PULLUP_OPT), 32'(O_STD_PULLUP_EN));
		chk("hv pull", I_HV_PULLDOWN_OPT, O_HV_PULLDOWN_EN);
		I_RESET = 0;
		step();
	endtask : t_reset
	task t_active;
		I_MODE = MODE_ACTIVE;
		step();
		chk("std oe", 32'(I_STD_PORT_DIRECTION_REGISTER), 32'(O_STD_OE));
		chk("hv out", I_HV_PORT_OUTPUT_REGISTER, O_HV_OUT);
		chk("std pull", 32'(I_STD_PULLUP_OPT), 32'(O_STD_PULLUP_EN));
		chk("hvin", 1, 32'(O_HVIN_IN_EN));
		chk("hv pull act", 0, O_HV_PULLDOWN_EN);
		I_HV_INPUT_OPT = 0;
		step();
		chk("hvin no opt", 0, 32'(O_HVIN_IN_EN));
		I_HV_INPUT_OPT = 1;
	endtask : t_active
	task t_sleep;
		// Data changes on the entry edge itself: the held value must be the pre-sleep one
		old = I_STD_PORT_OUTPUT_REGISTER;
		I_MODE = MODE_SLEEP;
		I_STD_PORT_OUTPUT_REGISTER = ~old;
		old_hv = I_HV_PORT_OUTPUT_REGISTER;
		I_HV_PORT_OUTPUT_REGISTER = ~old_hv;
		step();
		step();
		chk("held", 32'(old & I_STD_PORT_DIRECTION_REGISTER), 32'(O_STD_OUT & O_STD_OE));
		chk("hv held", old_hv & I_HV_PORT_DIRECTION_REGISTER, O_HV_OUT & O_HV_OE);
		chk("level", 32'((old & I_STD_PORT_DIRECTION_REGISTER) | (I_STD_PULLUP_OPT & ~I_STD_PORT_DIRECTION_REGISTER)),
			32'(lvl & (O_STD_OE | I_STD_PULLUP_OPT)));
	endtask : t_sleep
	task t_deep;
		// Codes past subactive are illegal and must leave everything off except peripheral input gates
		for (int m = 2; m < 8; m++) begin
			I_MODE = op_mode_t'(m[2:0]);
			step();
			chk("std pull", 0, 32'(O_STD_PULLUP_EN | O_STD_OE));
			chk("hv pull", (m < 5) ? I_HV_PULLDOWN_OPT : HV_ZERO, O_HV_PULLDOWN_EN);
			chk("periph", I_HV_PERIPH_IN, O_HV_IN_EN & I_HV_PERIPH_IN);
			chk("std periph", 32'(I_STD_PERIPH_IN), 32'(O_STD_IN_EN & I_STD_PERIPH_IN));
			chk("hvin", 0, 32'(O_HVIN_IN_EN));
		end
	endtask : t_deep
	initial begin
		t_reset();
		t_active();
		t_sleep();
		t_deep();
		t_active();
		t_reset();
		end_of_test();
	end
endmodule : port_low_power_pin_states_test
`default_nettype wire
